// file: src/bwpc_pkg.sv
package bwpc_pkg;
  // =====================================================
  // region width codes, as held in region_bus_config
  localparam logic [1:0]  W8            = 2'h0;
  localparam logic [1:0]  W16           = 2'h1;
  localparam logic [1:0]  W32           = 2'h2;
  // parity polarity: 0 gives even parity per byte
  localparam logic        PARITY_ODD    = 1'h0;
  // cycle kind fields
  localparam logic        KIND_MSB      = 1'h0;
  localparam int          KIND_EVT_BIT  = 2;
  // region select: top address bits pick one of 16 regions
  localparam int          REGIONS       = 16;
  localparam int          REGION_LSB    = 28;
  // register map (byte addresses)
  localparam logic [7:0]  CFG_BASE      = 8'h00;
  localparam logic [7:0]  CTRL_OFF      = 8'h40;
  localparam logic [7:0]  STAT_OFF      = 8'h44;
  // region_bus_config fields
  localparam int          CFG_WIDTH_LSB = 0;
  localparam int          CFG_PAR_BIT   = 2;
  localparam logic [2:0]  CFG_RESET     = 3'h2;
  // control fields
  localparam int          CTRL_FAULT_BIT = 0;
  localparam logic        CTRL_RESET     = 1'h1;
  // status fields
  localparam int          STAT_BUSY_BIT  = 16;
  localparam logic [15:0] CNT_RESET      = 16'h0000;

  typedef enum logic [1:0] {
    BWPC_IDLE = 2'b00,
    BWPC_ADDR = 2'b01,
    BWPC_DATA = 2'b10
  } bwpc_state_t;
endpackage

// file: src/bwpc_lane.sv
`timescale 1ns/1ps
module bwpc_lane (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // core access request
  input  wire logic        acc_valid_i,
  input  wire logic [31:0] acc_addr_i,
  input  wire logic [3:0]  acc_be_n_i,
  input  wire logic        acc_write_i,
  input  wire logic        acc_event_i,
  input  wire logic [31:0] acc_wdata_i,
  output logic             acc_ready_o,
  output logic             rd_valid_o,
  output logic      [31:0] rd_data_o,
  // external bus
  input  wire logic        hold_grant_i,
  input  wire logic        ready_n_i,
  input  wire logic [31:0] data_i,
  input  wire logic [3:0]  byte_parity_i,
  output logic             address_strobe_n_o,
  output logic      [31:2] addr_o,
  output logic      [3:0]  lane_select_n_o,
  output logic      [3:0]  cycle_kind_o,
  output logic             bus_oe_o,
  output logic      [31:0] data_o,
  output logic      [3:0]  byte_parity_o,
  output logic             data_oe_o,
  output logic             parity_error_n_o,
  output logic             fault_a_o
);

  // ==================================================
  // state
  typedef struct packed {
    bwpc_pkg::bwpc_state_t state;
    logic [bwpc_pkg::REGIONS-1:0][2:0] cfg;
    logic        fault_en;
    logic [15:0] err_cnt;
    logic [31:0] wb_dat;
    logic        wb_ack;
    logic        acc_ready;
    logic        rd_valid;
    logic [31:0] rd_data;
    logic        as_n;
    logic [31:2] addr;
    logic [3:0]  sel_n;
    logic [3:0]  kind;
    logic        bus_oe;
    logic [31:0] dout;
    logic [3:0]  dpar;
    logic        doe;
    logic        perr_n;
    logic        fault;
    logic [1:0]  width;
    logic        is_write;
    logic        chk_en;
  } bwpc_regs_t;

  bwpc_regs_t s;
  bwpc_regs_t next_s;

  // ==================================================
  // per-byte parity
  logic [31:0] store_data;
  logic [3:0]  gen_par;
  logic [3:0]  rx_par;
  logic [3:0]  acc_region;
  logic [1:0]  acc_width;

  assign acc_region = acc_addr_i[bwpc_pkg::REGION_LSB+3:bwpc_pkg::REGION_LSB];
  assign acc_width  = s.cfg[acc_region][bwpc_pkg::CFG_WIDTH_LSB+1:bwpc_pkg::CFG_WIDTH_LSB];

  always_comb begin
    if (acc_width == bwpc_pkg::W8) begin
      store_data = {4{acc_wdata_i[8*acc_addr_i[1:0] +: 8]}};
    end else if (acc_width == bwpc_pkg::W16) begin
      store_data = {2{acc_wdata_i[16*acc_addr_i[1] +: 16]}};
    end else begin
      store_data = acc_wdata_i;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_par
      assign gen_par[g] = (^store_data[8*g +: 8]) ^ bwpc_pkg::PARITY_ODD;
      assign rx_par[g]  = (^data_i[8*g +: 8]) ^ bwpc_pkg::PARITY_ODD;
    end
  endgenerate

  // ==================================================
  // next state
  logic [3:0]  next_sel;
  logic        data_done;
  logic        par_fail;
  logic [31:0] steered_rd;
  logic [4:0]  widx;

  always_comb begin
    next_s     = s;
    next_sel   = acc_be_n_i;
    data_done  = (s.state == bwpc_pkg::BWPC_DATA) && !ready_n_i;
    // only pin data is looked at
    // check loads and fetches in enabled regions only
    par_fail   = data_done && !s.is_write && s.chk_en && (rx_par != byte_parity_i);
    widx       = wb_adr_i[6:2];
    steered_rd = data_i;

    // narrow data on low lanes, returned to every lane
    if (s.width == bwpc_pkg::W8) begin
      steered_rd = {4{data_i[7:0]}};
    end else if (s.width == bwpc_pkg::W16) begin
      steered_rd = {2{data_i[15:0]}};
    end

    // 8-bit: selects carry A1:A0, upper two unused
    // 16-bit: A1, upper and lower byte selects
    if (acc_width == bwpc_pkg::W8) begin
      next_sel = {2'h3, acc_addr_i[1:0]};
    end else if (acc_width == bwpc_pkg::W16) begin
      next_sel = {acc_be_n_i[2*acc_addr_i[1]+1], 1'h1, acc_addr_i[1], acc_be_n_i[2*acc_addr_i[1]]};
    end

    // wishbone slave: ack one cycle after the strobe, then drop
    next_s.wb_ack = wb_cyc_i && wb_stb_i && !s.wb_ack;
    next_s.wb_dat = 32'h0000_0000;
    if (wb_cyc_i && wb_stb_i && !s.wb_ack) begin
      if (wb_adr_i[7:6] == 2'h0) begin
        next_s.wb_dat[2:0] = s.cfg[widx[3:0]];
        if (wb_we_i && wb_sel_i[0]) begin
          // code 3 is not a width; folded onto 32 so no reserved kind appears
          next_s.cfg[widx[3:0]] = {wb_dat_i[bwpc_pkg::CFG_PAR_BIT],
                                   (wb_dat_i[1:0] == 2'h3) ? bwpc_pkg::W32 : wb_dat_i[1:0]};
        end
      end else if (wb_adr_i == bwpc_pkg::CTRL_OFF) begin
        next_s.wb_dat[bwpc_pkg::CTRL_FAULT_BIT] = s.fault_en;
        if (wb_we_i && wb_sel_i[0]) begin
          next_s.fault_en = wb_dat_i[bwpc_pkg::CTRL_FAULT_BIT];
        end
      end else if (wb_adr_i == bwpc_pkg::STAT_OFF) begin
        next_s.wb_dat[15:0] = s.err_cnt;
        next_s.wb_dat[bwpc_pkg::STAT_BUSY_BIT] = (s.state != bwpc_pkg::BWPC_IDLE);
        if (wb_we_i && wb_sel_i[0]) begin
          next_s.err_cnt = bwpc_pkg::CNT_RESET;
        end
      end
    end
    // counting wins over a clear in the same cycle
    if (par_fail && s.err_cnt != 16'hffff) begin
      next_s.err_cnt = s.err_cnt + 16'h0001;
    end

    // low for one clock after the failing cycle
    // never floated, hold grant has no effect here
    next_s.perr_n = !par_fail;
    next_s.fault  = par_fail && s.fault_en;

    next_s.rd_valid = 1'h0;
    next_s.as_n     = 1'h1;
    case (s.state)
      bwpc_pkg::BWPC_IDLE: begin
        if (acc_valid_i && s.acc_ready) begin
          next_s.state    = bwpc_pkg::BWPC_ADDR;
          next_s.as_n     = 1'h0;
          next_s.addr     = acc_addr_i[31:2];
          next_s.sel_n    = next_sel;
          next_s.width    = acc_width;
          next_s.is_write = acc_write_i;
          next_s.chk_en   = s.cfg[acc_region][bwpc_pkg::CFG_PAR_BIT];
          // region width, source kind, msb low
          next_s.kind     = {bwpc_pkg::KIND_MSB, acc_event_i, acc_width};
          next_s.bus_oe   = 1'h1;
          next_s.dout     = store_data;
          next_s.dpar     = gen_par;
        end
      end
      bwpc_pkg::BWPC_ADDR: begin
        next_s.state = bwpc_pkg::BWPC_DATA;
        next_s.doe   = s.is_write;
      end
      bwpc_pkg::BWPC_DATA: begin
        if (data_done) begin
          next_s.state    = bwpc_pkg::BWPC_IDLE;
          next_s.doe      = 1'h0;
          next_s.rd_valid = !s.is_write;
          next_s.rd_data  = steered_rd;
        end
      end
      default: begin
        next_s.state = bwpc_pkg::BWPC_IDLE;
      end
    endcase
    if (next_s.state == bwpc_pkg::BWPC_IDLE && hold_grant_i) begin
      next_s.bus_oe = 1'h0;
    end
    next_s.acc_ready = (next_s.state == bwpc_pkg::BWPC_IDLE) && !hold_grant_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s          <= '0;
      s.state    <= bwpc_pkg::BWPC_IDLE;
      s.cfg      <= {bwpc_pkg::REGIONS{bwpc_pkg::CFG_RESET}};
      s.fault_en <= bwpc_pkg::CTRL_RESET;
      s.err_cnt  <= bwpc_pkg::CNT_RESET;
      s.as_n     <= 1'h1;
      s.sel_n    <= 4'hf;
      s.perr_n   <= 1'h1;
      s.width    <= bwpc_pkg::W32;
      s.kind     <= {bwpc_pkg::KIND_MSB, 1'h0, bwpc_pkg::W32};
    end else begin
      s <= next_s;
    end
  end

  // ==================================================
  // outputs
  assign wb_dat_o           = s.wb_dat;
  assign wb_ack_o           = s.wb_ack;
  assign acc_ready_o        = s.acc_ready;
  assign rd_valid_o         = s.rd_valid;
  assign rd_data_o          = s.rd_data;
  assign address_strobe_n_o = s.as_n;
  assign addr_o             = s.addr;
  assign lane_select_n_o    = s.sel_n;
  assign cycle_kind_o       = s.kind;
  assign bus_oe_o           = s.bus_oe;
  assign data_o             = s.dout;
  assign byte_parity_o      = s.dpar;
  assign data_oe_o          = s.doe;
  assign parity_error_n_o   = s.perr_n;
  assign fault_a_o          = s.fault;

  // ==================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [3:0] chk_par;
  assign chk_par = {^s.dout[31:24], ^s.dout[23:16], ^s.dout[15:8], ^s.dout[7:0]} ^ {4{bwpc_pkg::PARITY_ODD}};

  chk_parity_error_n_pulse: assert property (par_fail |=> !parity_error_n_o) else $error("parity error pin not low");
  chk_parity_error_n_idle: assert property (!par_fail |=> parity_error_n_o) else $error("parity error pin low without cause");
  chk_parity_error_n_b2b: assert property (par_fail ##1 par_fail |=> !parity_error_n_o && $past(!parity_error_n_o))
    else $error("back-to-back error not held");
  chk_no_store_chk: assert property (s.is_write |-> !par_fail) else $error("store data was checked");
  chk_dp_timing: assert property (data_oe_o |-> byte_parity_o == chk_par) else $error("parity not matching data");
  chk_rep8: assert property (data_oe_o && s.width == bwpc_pkg::W8 |-> data_o == {4{data_o[7:0]}})
    else $error("byte not repeated");
  chk_rep16: assert property (data_oe_o && s.width == bwpc_pkg::W16 |-> data_o[31:16] == data_o[15:0])
    else $error("halfword not repeated");
  chk_sel8: assert property (!address_strobe_n_o && s.width == bwpc_pkg::W8 |->
    lane_select_n_o[1:0] == $past(acc_addr_i[1:0])) else $error("8-bit select encoding wrong");
  chk_kind_msb: assert property (cycle_kind_o[3] == 1'h0 && cycle_kind_o[1:0] != 2'h3) else $error("reserved kind");
  chk_kind_width: assert property (!address_strobe_n_o |-> cycle_kind_o[1:0] == s.width ##1
    (cycle_kind_o == $past(cycle_kind_o) && addr_o == $past(addr_o))) else $error("kind not tied to region width");
  chk_fault_pair: assert property (fault_a_o |-> !parity_error_n_o) else $error("fault without parity error");

  cov_err: cover property (par_fail ##1 !parity_error_n_o);
  cov_b2b: cover property (par_fail ##1 par_fail);
  cov_store8: cover property (data_oe_o && s.width == bwpc_pkg::W8);
  cov_event: cover property (!address_strobe_n_o && cycle_kind_o[bwpc_pkg::KIND_EVT_BIT]);

endmodule

// file: verif/bwpc_mem.sv
`timescale 1ns/1ps
// ==========================================
// far side memory: one data cycle per strobe
module bwpc_mem (
  // design pins
  input  wire logic        clk_i,
  input  wire logic        as_n_i,
  input  wire logic        oe_i,
  input  wire logic [31:0] wd_i,
  input  wire logic [3:0]  wp_i,
  // bench controls
  input  wire logic [3:0]  waits_i,
  input  wire logic        bad_i,
  input  wire logic [31:0] rdata_i,
  // answers
  output logic             ready_n_o,
  output logic      [31:0] data_o,
  output logic      [3:0]  par_o,
  output logic      [31:0] last_w_o,
  output logic      [3:0]  last_p_o
);
  logic       busy = 1'b0;
  logic [3:0] cnt  = 4'h0;
  logic [3:0] par;
  initial ready_n_o = 1'b1;
  // even parity per byte, bit 0 flipped on demand
  always_comb begin
    for (int i = 0; i < 4; i++) par[i] = ^rdata_i[8*i+:8];
  end
  // undriven bus shows inverted data so stale values never match
  assign data_o = ready_n_o ? ~rdata_i : rdata_i;
  assign par_o  = ready_n_o ? ~par : (par ^ {3'h0, bad_i});
  always @(posedge clk_i) begin
    if (!as_n_i) begin
      busy      <= 1'b1;
      cnt       <= waits_i;
      ready_n_o <= (waits_i != 4'h0);
    end else if (busy && ready_n_o) begin
      cnt       <= cnt - 4'h1;
      ready_n_o <= (cnt > 4'h1);
    end else if (busy) begin
      busy      <= 1'b0;
      ready_n_o <= 1'b1;
    end
    if (!ready_n_o && oe_i) begin
      last_w_o <= wd_i;
      last_p_o <= wp_i;
    end
  end
endmodule

// file: verif/tb_bwpc_lane.sv
`timescale 1ns/1ps
module tb_bwpc_lane;
  // ==========================================
  // stimulus and wires
  logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, acc_valid_i = 0;
  logic        acc_write_i = 0, acc_event_i = 0, hold_grant_i = 0, bad = 0, rdv, pe, flt;
  logic [7:0]  wb_adr_i = 0;
  logic [3:0]  wb_sel_i = 4'hf, acc_be_n_i = 4'hf, waits = 4'h0, mpar, par_o, lsel, kind, lp;
  logic [31:0] wb_dat_i = 0, acc_addr_i = 0, acc_wdata_i = 0, rdata = 0, wb_dat_o, rd_data_o, mdata, data_o, lw, rdd;
  logic [31:2] addr_o;
  logic        wb_ack_o, acc_ready_o, rd_valid_o, ready_n, as_n, bus_oe, data_oe, pe_n, fault;
  int          err_count = 0, total_checks = 0, cycles = 0;
  always #10 clk_i = ~clk_i;
  bwpc_lane bwpc_lane_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .acc_valid_i(acc_valid_i), .acc_addr_i(acc_addr_i), .acc_be_n_i(acc_be_n_i),
    .acc_write_i(acc_write_i), .acc_event_i(acc_event_i), .acc_wdata_i(acc_wdata_i), .acc_ready_o(acc_ready_o),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .hold_grant_i(hold_grant_i), .ready_n_i(ready_n),
    .data_i(mdata), .byte_parity_i(mpar), .address_strobe_n_o(as_n), .addr_o(addr_o), .lane_select_n_o(lsel),
    .cycle_kind_o(kind), .bus_oe_o(bus_oe), .data_o(data_o), .byte_parity_o(par_o), .data_oe_o(data_oe),
    .parity_error_n_o(pe_n), .fault_a_o(fault));
  bwpc_mem bwpc_mem_inst (.clk_i(clk_i), .as_n_i(as_n), .oe_i(data_oe), .wd_i(data_o), .wp_i(par_o),
    .waits_i(waits), .bad_i(bad), .rdata_i(rdata), .ready_n_o(ready_n), .data_o(mdata), .par_o(mpar),
    .last_w_o(lw), .last_p_o(lp));
  // ==========================================
  // shared tasks
  task automatic chk(input bit ok, input string msg);
    total_checks++;
    if (!ok) begin
      err_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic acc(input logic [31:0] a, input logic [3:0] be, input logic w, input logic e,
                     input logic [31:0] d);
    @(posedge clk_i);
    while (acc_ready_o !== 1'b1) @(posedge clk_i);
    {acc_valid_i, acc_addr_i, acc_be_n_i, acc_write_i, acc_event_i, acc_wdata_i} <= {1'b1, a, be, w, e, d};
    @(posedge clk_i);
    acc_valid_i <= 1'b0;
    do begin
      @(posedge clk_i);
      #1 {rdv, rdd, pe, flt} = {rd_valid_o, rd_data_o, pe_n, fault};
    end while (acc_ready_o !== 1'b1);
  endtask
  function automatic logic [3:0] epar(input logic [31:0] d);
    for (int i = 0; i < 4; i++) epar[i] = ^d[8*i+:8];
  endfunction
  // ==========================================
  // scenarios
  task automatic t_width;
    logic [31:0] m, x, k;
    logic [1:0]  w;
    for (int i = 0; i < 6; i++) begin
      w = 2'(i % 3);
      wb(1'b1, 8'h04, {30'h0, w}, k);
      acc(32'h1000_0001, 4'hd, 1'b1, i > 2, 32'h0000_a700);
      x = (w == bwpc_pkg::W8) ? 32'ha7a7a7a7 : (w == bwpc_pkg::W16) ? 32'ha700a700 : 32'h0000a700;
      m = (w == bwpc_pkg::W32) ? 32'h0000ff00 : 32'hffffffff;
      chk((lw & m) === x, "store lanes");
      chk((lp & {m[24], m[16], m[8], m[0]}) === (epar(x) & {m[24], m[16], m[8], m[0]}), "store parity");
      chk(lsel === ((w == bwpc_pkg::W16) ? 4'h5 : 4'hd), "lane selects");
      chk(kind === {1'b0, i > 2, w == bwpc_pkg::W32, w == bwpc_pkg::W16}, "cycle kind");
      chk(addr_o === 30'h0400_0000, "address");
      rdata = 32'h0000_5ac3;
      acc(32'h1000_0000, 4'h0, 1'b0, i > 2, 32'h0);
      x = (w == bwpc_pkg::W8) ? 32'hc3c3c3c3 : (w == bwpc_pkg::W16) ? 32'h5ac35ac3 : 32'h00005ac3;
      chk(rdv === 1'b1 && rdd === x, "load lanes");
    end
    $display("width test done");
  endtask
  task automatic t_parity;
    logic [31:0] k;
    wb(1'b1, 8'h08, 32'h6, k);
    rdata = 32'h1234_5678;
    acc(32'h2000_0000, 4'h0, 1'b0, 1'b0, 32'h0);
    chk(rdv === 1'b1 && rdd === 32'h1234_5678 && pe === 1'b1, "clean load");
    bad = 1'b1;
    acc(32'h2000_0000, 4'h0, 1'b0, 1'b0, 32'h0);
    chk(pe === 1'b0 && flt === 1'b1, "error pulse");
    @(posedge clk_i);
    #1 chk(pe_n === 1'b1, "pulse length");
    wb(1'b0, bwpc_pkg::STAT_OFF, 32'h0, k);
    chk(k[15:0] === 16'h0001, "error count");
    wb(1'b1, 8'h08, 32'h2, k);
    waits = 4'h2;
    acc(32'h2000_0000, 4'h0, 1'b0, 1'b1, 32'h0);
    chk(pe === 1'b1 && rdv === 1'b1, "check disabled");
    chk(kind === 4'h6, "event kind");
    {bad, waits} = 5'h0;
    $display("parity test done");
  endtask
  task automatic t_misc;
    logic [31:0] k;
    wb(1'b0, 8'h0c, 32'h0, k);
    chk(k[2:0] === bwpc_pkg::CFG_RESET, "config reset");
    wb(1'b0, 8'h80, 32'h0, k);
    chk(k === 32'h0, "unmapped read");
    @(posedge clk_i);
    hold_grant_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1 chk(acc_ready_o === 1'b0 && pe_n === 1'b1, "hold");
    @(posedge clk_i);
    hold_grant_i <= 1'b0;
    $display("misc test done");
  endtask
  // ==========================================
  // main sequence and watchdog
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1 chk(lsel === 4'hf && kind === 4'h2 && pe_n === 1'b1 && as_n === 1'b1, "reset state");
    t_width();
    t_parity();
    t_misc();
    test_done();
  end
endmodule
